/* File: hdl/bwdr_regs.svh */
// Register offsets, field positions and reset values of the window decode bank.
// Assumes inclusion by bare name from the decode register module.
`ifndef BWDR_REGS_SVH
`define BWDR_REGS_SVH

`define BWDR_OFF_PF_WINDOW     8'h24
`define BWDR_OFF_PF_BASE_UP    8'h28
`define BWDR_OFF_PF_LIMIT_UP   8'h2c
`define BWDR_OFF_IO_UP         8'h30
`define BWDR_OFF_CAP_PTR       8'h34

`define BWDR_PF_BASE_LSB       4
`define BWDR_PF_BASE_MSB       15
`define BWDR_PF_WIDTH_LSB      0
`define BWDR_PF_WIDTH_MSB      3
`define BWDR_PF_LWIDTH_LSB     16
`define BWDR_PF_LWIDTH_MSB     19
`define BWDR_PF_LIMIT_LSB      20
`define BWDR_PF_LIMIT_MSB      31
`define BWDR_IO_BASE_LSB       0
`define BWDR_IO_BASE_MSB       15
`define BWDR_IO_LIMIT_LSB      16
`define BWDR_IO_LIMIT_MSB      31

`define BWDR_ADDR64_CODE       4'h1
`define BWDR_CAP_PTR_VALUE     8'hb0
`define BWDR_PF_FIELD_RST      12'h000
`define BWDR_UPPER_RST         32'h0000_0000
`define BWDR_IO_FIELD_RST      16'h0000
`define BWDR_PF_LOW_BASE       20'h00000
`define BWDR_PF_LOW_LIMIT      20'hfffff
`define BWDR_IO_LOW_BASE       12'h000
`define BWDR_IO_LOW_LIMIT      12'hfff

`endif

/* File: hdl/bwdr_pkg.sv */
// Types shared by the window decode bank.
// Assumes the constants header is on the include path.
package bwdr_pkg;
   typedef logic [31:0] bwdr_word_t;
   typedef logic [63:0] bwdr_addr64_t;
   typedef enum logic [1:0] {
      BWDR_IDLE   = 2'b00,
      BWDR_ACCESS = 2'b01
   } bwdr_state_t;
endpackage : bwdr_pkg

/* File: hdl/bwdr_range_cmp.sv */
// Inclusive window compare of one address against base and limit.
// Assumes base and limit are already assembled to full width.
`timescale 1ns/100ps
`default_nettype none
module bwdr_range_cmp #(
   parameter int unsigned W = 64
) (
   // Operands
   input  wire logic [W-1:0] addr,
   input  wire logic [W-1:0] base,
   input  wire logic [W-1:0] limit,
   // Result
   output logic              hit
);
   assign hit = (addr >= base) && (addr <= limit); // [R11]
endmodule : bwdr_range_cmp
`default_nettype wire

/* File: hdl/bwdr_decode_regs.sv */
// Prefetchable and upper I/O window registers with APB slave and forward decode.
// Assumes an APB master on pclk; transaction addresses arrive on pclk.
//
// Function
// R01: Prefetch base field bits 15:4 writable, gives address 31:20, low bits zero.
// R02: Read-only width code in bits 19:16, 0001 means 64-bit, reset 1.
// R03: Prefetch limit field bits 31:20 writable, low 20 address bits all ones.
// R04: Prefetch base and limit decide forwarding of memory reads and writes.
// R05: Writable 32-bit upper half of prefetch base, reset zero.
// R06: Writable 32-bit upper half of prefetch limit, reset zero.
// R07: Writable I/O base bits 31:16 in bits 15:0, reset zero, steers forwarding.
// R08: Writable I/O limit bits 31:16, reset zero, steers I/O forwarding.
// R09: Capabilities pointer bits 7:0 read-only, always returns b0.
// R10: I/O limit low 12 bits all ones, I/O base low bits zero.
// R11: Inside window when base <= address <= limit, full width compare.
// R12: Writes to read-only fields ignored, fixed values returned.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bwdr_regs.svh"
module bwdr_decode_regs (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Memory decode request
   input  wire logic [63:0] mem_addr,
   input  wire logic        mem_valid,
   output logic             mem_forward,
   // I/O decode request
   input  wire logic [31:0] io_addr,
   input  wire logic        io_valid,
   output logic             io_forward,
   // Assembled windows
   output logic [63:0]      pf_base,
   output logic [63:0]      pf_limit,
   output logic [31:0]      io_base_hi,
   output logic [31:0]      io_limit_hi
);

   // Prefetch window fields
   logic [11:0]           pf_base_q;
   logic [11:0]           pf_base_d;
   logic [11:0]           pf_limit_q;
   logic [11:0]           pf_limit_d;
   // Upper address words
   bwdr_pkg::bwdr_word_t  pf_bup_q;
   bwdr_pkg::bwdr_word_t  pf_bup_d;
   bwdr_pkg::bwdr_word_t  pf_lup_q;
   bwdr_pkg::bwdr_word_t  pf_lup_d;
   // Upper I/O halves
   logic [15:0]           io_base_q;
   logic [15:0]           io_base_d;
   logic [15:0]           io_limit_q;
   logic [15:0]           io_limit_d;
   // Read data
   bwdr_pkg::bwdr_word_t  prdata_q;
   bwdr_pkg::bwdr_word_t  prdata_d;
   // Forward results
   logic                  mem_fwd_q;
   logic                  mem_fwd_d;
   logic                  io_fwd_q;
   logic                  io_fwd_d;
   // Bus phase and decode
   bwdr_pkg::bwdr_state_t phase_q;
   bwdr_pkg::bwdr_state_t phase_d;
   logic                  wr_en;
   logic                  rd_en;
   logic                  addr_ok;
   logic                  sel_pf_win;
   logic                  sel_pf_bup;
   logic                  sel_pf_lup;
   logic                  sel_io;
   logic                  sel_cap;
   bwdr_pkg::bwdr_word_t  wmask;
   bwdr_pkg::bwdr_word_t  pf_word;
   bwdr_pkg::bwdr_word_t  io_word;
   bwdr_pkg::bwdr_word_t  cap_word;
   // Compare results
   logic                  mem_hit;
   logic                  io_hit;

   // APB phase tracker; writes count only after a setup cycle
   always_comb begin
      phase_d = phase_q;
      case (phase_q)
         bwdr_pkg::BWDR_IDLE: begin
            if (psel && !penable) begin
               phase_d = bwdr_pkg::BWDR_ACCESS;
            end
         end
         bwdr_pkg::BWDR_ACCESS: begin
            if (pready) begin
               phase_d = bwdr_pkg::BWDR_IDLE;
            end
         end
         default: begin
            // Unused codes return to idle
            phase_d = bwdr_pkg::BWDR_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_q <= bwdr_pkg::BWDR_IDLE;
      end else begin
         phase_q <= phase_d;
      end
   end

   // APB transfer qualifiers
   assign wr_en = psel && penable && pwrite && (phase_q == bwdr_pkg::BWDR_ACCESS);
   assign rd_en = psel && !penable && !pwrite;
   assign wmask = {{8{pstrb[3]}},
                   {8{pstrb[2]}},
                   {8{pstrb[1]}},
                   {8{pstrb[0]}}};

   // Register selects
   assign sel_pf_win = (paddr == `BWDR_OFF_PF_WINDOW);
   assign sel_pf_bup = (paddr == `BWDR_OFF_PF_BASE_UP);
   assign sel_pf_lup = (paddr == `BWDR_OFF_PF_LIMIT_UP);
   assign sel_io     = (paddr == `BWDR_OFF_IO_UP);
   assign sel_cap    = (paddr == `BWDR_OFF_CAP_PTR);
   assign addr_ok    = sel_pf_win
                    || sel_pf_bup
                    || sel_pf_lup
                    || sel_io
                    || sel_cap;

   // Zero-wait slave, error on unmapped offsets
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;
   assign prdata  = prdata_q;

   // Read views of the mixed words
   assign pf_word  = {pf_limit_q, `BWDR_ADDR64_CODE, pf_base_q, `BWDR_ADDR64_CODE}; // [R02]
   assign io_word  = {io_limit_q, io_base_q};
   // Fixed code, no storage behind it
   assign cap_word = {24'h00_0000, `BWDR_CAP_PTR_VALUE}; // [R09]

   // Assembled windows
   assign pf_base     = {pf_bup_q, pf_base_q, `BWDR_PF_LOW_BASE};   // [R01] [R05]
   assign pf_limit    = {pf_lup_q, pf_limit_q, `BWDR_PF_LOW_LIMIT}; // [R03] [R06]
   assign io_base_hi  = {io_base_q, 4'h0, `BWDR_IO_LOW_BASE};       // [R07] [R10]
   assign io_limit_hi = {io_limit_q, 4'hf, `BWDR_IO_LOW_LIMIT};     // [R08] [R10]

   // Inclusive window compares
   bwdr_range_cmp #(.W(64)) u_mem_cmp (
      .addr  (mem_addr),
      .base  (pf_base),
      .limit (pf_limit),
      .hit   (mem_hit)
   );

   bwdr_range_cmp #(.W(32)) u_io_cmp (
      .addr  (io_addr),
      .base  (io_base_hi),
      .limit (io_limit_hi),
      .hit   (io_hit)
   );

   assign mem_forward = mem_fwd_q;
   assign io_forward  = io_fwd_q;

   // Prefetch base and limit fields
   always_comb begin
      pf_base_d  = pf_base_q;
      pf_limit_d = pf_limit_q;
      if (wr_en && sel_pf_win) begin
         // Width codes at 19:16 and 3:0 are not stored
         pf_base_d  = (pf_base_q & ~wmask[`BWDR_PF_BASE_MSB:`BWDR_PF_BASE_LSB])
                    | (pwdata[`BWDR_PF_BASE_MSB:`BWDR_PF_BASE_LSB]
                       & wmask[`BWDR_PF_BASE_MSB:`BWDR_PF_BASE_LSB]); // [R01] [R12]
         pf_limit_d = (pf_limit_q & ~wmask[`BWDR_PF_LIMIT_MSB:`BWDR_PF_LIMIT_LSB])
                    | (pwdata[`BWDR_PF_LIMIT_MSB:`BWDR_PF_LIMIT_LSB]
                       & wmask[`BWDR_PF_LIMIT_MSB:`BWDR_PF_LIMIT_LSB]); // [R03] [R12]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pf_base_q  <= `BWDR_PF_FIELD_RST;
         pf_limit_q <= `BWDR_PF_FIELD_RST;
      end else begin
         pf_base_q  <= pf_base_d;
         pf_limit_q <= pf_limit_d;
      end
   end

   // Upper address words of the prefetch window
   always_comb begin
      pf_bup_d = pf_bup_q;
      pf_lup_d = pf_lup_q;
      if (wr_en && sel_pf_bup) begin
         pf_bup_d = (pf_bup_q & ~wmask) | (pwdata & wmask); // [R05]
      end
      if (wr_en && sel_pf_lup) begin
         pf_lup_d = (pf_lup_q & ~wmask) | (pwdata & wmask); // [R06]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pf_bup_q <= `BWDR_UPPER_RST;
         pf_lup_q <= `BWDR_UPPER_RST;
      end else begin
         pf_bup_q <= pf_bup_d;
         pf_lup_q <= pf_lup_d;
      end
   end

   // Upper I/O halves, base in 15:0 and limit in 31:16
   always_comb begin
      io_base_d  = io_base_q;
      io_limit_d = io_limit_q;
      if (wr_en && sel_io) begin
         io_base_d  = (io_base_q & ~wmask[`BWDR_IO_BASE_MSB:`BWDR_IO_BASE_LSB])
                    | (pwdata[`BWDR_IO_BASE_MSB:`BWDR_IO_BASE_LSB]
                       & wmask[`BWDR_IO_BASE_MSB:`BWDR_IO_BASE_LSB]); // [R07]
         io_limit_d = (io_limit_q & ~wmask[`BWDR_IO_LIMIT_MSB:`BWDR_IO_LIMIT_LSB])
                    | (pwdata[`BWDR_IO_LIMIT_MSB:`BWDR_IO_LIMIT_LSB]
                       & wmask[`BWDR_IO_LIMIT_MSB:`BWDR_IO_LIMIT_LSB]); // [R08]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_base_q  <= `BWDR_IO_FIELD_RST;
         io_limit_q <= `BWDR_IO_FIELD_RST;
      end else begin
         io_base_q  <= io_base_d;
         io_limit_q <= io_limit_d;
      end
   end

   // Read data, loaded in the setup cycle of a read
   // Capability pointer has no write path at all [R12]
   always_comb begin
      prdata_d = prdata_q;
      if (rd_en) begin
         case (paddr)
            `BWDR_OFF_PF_WINDOW: begin
               prdata_d = pf_word;
            end
            `BWDR_OFF_PF_BASE_UP: begin
               prdata_d = pf_bup_q;
            end
            `BWDR_OFF_PF_LIMIT_UP: begin
               prdata_d = pf_lup_q;
            end
            `BWDR_OFF_IO_UP: begin
               prdata_d = io_word;
            end
            `BWDR_OFF_CAP_PTR: begin
               prdata_d = cap_word; // [R09]
            end
            default: begin
               prdata_d = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

   // Forward decisions, registered one cycle after the request
   always_comb begin
      mem_fwd_d = 1'b0;
      io_fwd_d  = 1'b0;
      if (mem_valid) begin
         mem_fwd_d = mem_hit; // [R04]
      end
      if (io_valid) begin
         io_fwd_d = io_hit; // [R07] [R08]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_fwd_q <= 1'b0;
         io_fwd_q  <= 1'b0;
      end else begin
         mem_fwd_q <= mem_fwd_d;
         io_fwd_q  <= io_fwd_d;
      end
   end
endmodule : bwdr_decode_regs
`default_nettype wire

/* File: test/bwdr_assertions.sv */
// Checker for the window decode bank.
// Assumes one pclk domain, presetn async reset.
`timescale 1ns/100ps
`default_nettype none
module bwdr_assertions (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Decode requests and results
   input wire logic        mem_valid,
   input wire logic [63:0] mem_addr,
   input wire logic        mem_forward,
   input wire logic        io_valid,
   input wire logic [31:0] io_addr,
   input wire logic        io_forward,
   // Assembled windows
   input wire logic [63:0] pf_base,
   input wire logic [63:0] pf_limit,
   input wire logic [31:0] io_base_hi,
   input wire logic [31:0] io_limit_hi
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rd_set = psel && !penable && !pwrite;
   AST_PF_BASE_LOW: assert property (pf_base[19:0] == 20'h00000)
      else $error("pf base low bits");
   AST_PF_LIMIT_LOW: assert property (pf_limit[19:0] == 20'hfffff)
      else $error("pf limit low bits");
   AST_IO_LOW: assert property (
      io_base_hi[11:0] == 12'h000 && io_limit_hi[11:0] == 12'hfff)
      else $error("io low bits");
   AST_MEM_HIT: assert property (
      mem_valid && mem_addr >= pf_base && mem_addr <= pf_limit |=> mem_forward)
      else $error("mem hit lost");
   AST_MEM_MISS: assert property (
      !mem_valid || mem_addr < pf_base || mem_addr > pf_limit |=> !mem_forward)
      else $error("mem miss forwarded");
   AST_IO_HIT: assert property (
      io_valid && io_addr >= io_base_hi && io_addr <= io_limit_hi |=> io_forward)
      else $error("io hit lost");
   AST_CAP: assert property (
      rd_set && paddr == 8'h34 |=> prdata == 32'h0000_00b0)
      else $error("cap pointer");
   AST_WIDTH: assert property (
      rd_set && paddr == 8'h24 |=> prdata[19:16] == 4'h1 && prdata[3:0] == 4'h1)
      else $error("width code");
   AST_BASE_UP: assert property (
      psel && penable && pwrite && paddr == 8'h28 && &pstrb |=> pf_base[63:32] == $past(pwdata))
      else $error("base upper word");
   COV_MEM: cover property (mem_valid ##1 mem_forward);
   COV_IO: cover property (io_valid ##1 io_forward);
   COV_WR: cover property (psel && penable && pwrite);
endmodule : bwdr_assertions
bind bwdr_decode_regs bwdr_assertions chk_u (.*);
`default_nettype wire

/* File: test/bwdr_host.sv */
// Host model: APB master, one transfer at a time.
// Assumes tb_top holds the counters and closing report.
`timescale 1ns/100ps
`default_nettype none
module bwdr_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output var  logic        psel = 0,
   output var  logic        penable = 0,
   output var  logic        pwrite = 0,
   output var  logic [7:0]  paddr = 0,
   output var  logic [31:0] pwdata = 0,
   output var  logic [3:0]  pstrb = 4'hf
);
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) begin
         tb_top.mismatches++;
         tb_top.print_verdict();
      end
      r = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : xfer
endmodule : bwdr_host
`default_nettype wire

/* File: test/tb_top.sv */
// Bench for the window decode bank.
// Assumes the host model drives the register bus.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, e;
   logic        mem_valid = 0, io_valid = 0, mem_forward, io_forward;
   logic [7:0]  paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, io_addr = 0, io_base_hi, io_limit_hi, q;
   logic [63:0] mem_addr = 0, pf_base, pf_limit;
   int          mismatches = 0, num_checks = 0;
   initial forever #5 pclk = ~pclk;
   bwdr_decode_regs dut_u (.*);
   bwdr_host host_u (.*);
   task chk(input string n, input logic [63:0] x, s);
      num_checks++;
      if (s !== x) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task print_verdict;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task t_reset;
      logic [31:0] v [5] = '{32'h0001_0001, 0, 0, 0, 32'h0000_00b0};
      for (int i = 0; i < 5; i++) begin
         host_u.xfer(0, 8'h24 + 8'(4 * i), 0, q, e);
         chk("reset", v[i], q);
      end
   endtask : t_reset
   task t_rw;
      host_u.xfer(1, 8'h24, 32'hffff_ffff, q, e);
      host_u.xfer(1, 8'h34, 0, q, e);
      host_u.xfer(1, 8'h38, 32'h1, q, e);
      chk("unmapped err", 1, e);
      host_u.xfer(0, 8'h38, 0, q, e);
      chk("unmapped read", 0, q);
      chk("unmapped read err", 1, e);
      host_u.pstrb <= 4'h1;
      host_u.xfer(1, 8'h28, 32'hffff_ffff, q, e);
      host_u.pstrb <= 4'hf;
      host_u.xfer(0, 8'h28, 0, q, e);
      chk("byte lane", 32'h0000_00ff, q);
      host_u.xfer(0, 8'h24, 0, q, e);
      chk("window word", 32'hfff1_fff1, q);
      host_u.xfer(0, 8'h34, 0, q, e);
      chk("cap pointer", 32'hb0, q);
   endtask : t_rw
   task t_mem;
      logic [63:0] a [5] = '{64'h1_0fff_ffff, 64'h1_1000_0000, 64'h1_200f_ffff,
                             64'h1_2010_0000, 64'h1_1000_0000};
      host_u.xfer(1, 8'h24, 32'h2000_1000, q, e);
      host_u.xfer(1, 8'h28, 32'h1, q, e);
      host_u.xfer(1, 8'h2c, 32'h1, q, e);
      host_u.xfer(0, 8'h2c, 0, q, e);
      chk("limit upper", 1, q);
      chk("pf_base", 64'h1_1000_0000, pf_base);
      chk("pf_limit", 64'h1_200f_ffff, pf_limit);
      for (int i = 0; i < 5; i++) begin
         @(posedge pclk);
         mem_addr <= a[i];
         mem_valid <= i < 4;
         @(posedge pclk);
         @(negedge pclk);
         chk("mem_forward", i == 1 || i == 2, mem_forward);
      end
      @(posedge pclk);
      mem_valid <= 0;
   endtask : t_mem
   task t_io;
      logic [31:0] a [4] = '{32'h0000_ffff, 32'h0001_0000, 32'h0002_ffff, 32'h0003_0000};
      host_u.xfer(1, 8'h30, 32'h0002_0001, q, e);
      host_u.xfer(0, 8'h30, 0, q, e);
      chk("io word", 32'h0002_0001, q);
      chk("io_limit_hi", 32'h0002_ffff, io_limit_hi);
      chk("io_base_hi", 32'h0001_0000, io_base_hi);
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         io_addr <= a[i];
         io_valid <= 1;
         @(posedge pclk);
         @(negedge pclk);
         chk("io_forward", i == 1 || i == 2, io_forward);
      end
      @(posedge pclk);
      io_valid <= 0;
   endtask : t_io
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_rw();
      t_mem();
      t_io();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
